// File: rtl/lcou_pkg.sv
/*
 * lcou_pkg: constants and types for the light control override unit.
 * Assumes a 10 MHz system clock and a classic 32-bit Wishbone register bus.
 */
package lcou_pkg;
   localparam int CLK_HZ = 10_000_000;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DISABLE = 8'h04;
   localparam logic [7:0] REG_PRESENCE = 8'h08;
   localparam logic [7:0] REG_OVR_SWITCH = 8'h0C;
   localparam logic [7:0] REG_OVR_DIM = 8'h10;
   localparam logic [7:0] REG_OVR_BRIGHT = 8'h14;
   localparam logic [7:0] REG_OVR_SCENE = 8'h18;
   localparam logic [7:0] REG_MEASURED = 8'h1C;
   localparam logic [7:0] REG_SETPOINT = 8'h20;
   localparam logic [7:0] REG_FEEDBACK = 8'h24;
   localparam logic [7:0] REG_STATUS = 8'h28;
   localparam logic [7:0] REG_LAST_OVR = 8'h2C;
   // control register fields
   localparam int CTRL_END_MODE_LSB = 0;
   localparam int CTRL_ALLOW_OVR_BIT = 2;
   localparam int CTRL_REENABLE_BIT = 3;
   localparam int CTRL_COUPLED_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // end-of-disable modes
   localparam logic [1:0] END_NO_TELEGRAM = 2'h0;
   localparam logic [1:0] END_SWITCH_OFF = 2'h1;
   localparam logic [1:0] END_STARTUP = 2'h2;
   // reset values of data registers, and command brightness values
   localparam logic [7:0] MEASURED_RESET = 8'h00;
   localparam logic [7:0] SETPOINT_RESET = 8'h80;
   localparam logic [7:0] FEEDBACK_RESET = 8'h00;
   localparam logic [7:0] BRIGHT_ON = 8'hFF;
   localparam logic [7:0] BRIGHT_OFF = 8'h00;
   // timing
   localparam int STEPDOWN_US = 100;
   localparam int STEPDOWN_CYC = (STEPDOWN_US * (CLK_HZ / 1_000_000) > 0) ?
                                 STEPDOWN_US * (CLK_HZ / 1_000_000) : 1;
   localparam int TX_DELAY_US = 50;
   localparam int TX_DELAY_CYC = (TX_DELAY_US * (CLK_HZ / 1_000_000) > 0) ?
                                 TX_DELAY_US * (CLK_HZ / 1_000_000) : 1;
   localparam int TIMER_W = 12;

   typedef enum logic [2:0] {
      LC_OFF,
      LC_STARTUP,
      LC_MAIN,
      LC_STEPDOWN,
      LC_DISABLED,
      LC_OVERRIDE
   } lcou_state_type;

   typedef struct packed {
      logic [1:0] end_mode;
      logic allow_ovr;
      logic reenable_by_disable;
      logic coupled_fb1;
   } lcou_cfg_type;

   typedef struct packed {
      logic send;
      logic on;
      logic [7:0] value;
   } lcou_cmd_type;
endpackage : lcou_pkg

// File: rtl/lcou_top.sv
/*
 * lcou_top: end-of-disable and superimposed (manual) operation state logic
 * of a presence-driven light control, with a classic Wishbone slave.
 * Assumes telegrams are decoded elsewhere and delivered as register writes
 * on the same clock; output telegrams leave as one-cycle command pulses.
 */
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module lcou_top
   import lcou_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output lcou_cmd_type cmd_out,
   output logic disabled_out,
   output logic override_out
);
   lcou_cfg_type cfg;
   lcou_state_type state;
   logic [7:0] measured;
   logic [7:0] setpoint;
   logic [7:0] feedback;
   logic presence;
   logic synthetic;
   logic ext_disable;
   logic [TIMER_W-1:0] timer;
   logic tx_wait;
   logic [1:0] last_ovr_src;
   logic [7:0] last_ovr_val;

   // a write takes effect at the edge where the master sees ack
   logic wr;
   logic wr_lane0;
   assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
   assign wr_lane0 = wr && wb_sel_in[0];

   logic ev_disable;
   logic ev_enable;
   logic ev_presence;
   logic ev_ovr;
   assign ev_disable = wr_lane0 && (wb_adr_in == REG_DISABLE) && wb_dat_in[0];
   assign ev_enable = wr_lane0 && (wb_adr_in == REG_DISABLE) && !wb_dat_in[0];
   assign ev_presence = wr_lane0 && (wb_adr_in == REG_PRESENCE);
   assign ev_ovr = wr_lane0 && cfg.allow_ovr &&
                   ((wb_adr_in == REG_OVR_SWITCH) || (wb_adr_in == REG_OVR_DIM) ||
                    (wb_adr_in == REG_OVR_BRIGHT) || (wb_adr_in == REG_OVR_SCENE));

   logic below_setpoint;
   assign below_setpoint = measured < setpoint;

   // wishbone handshake: one wait cycle, ack drops the cycle after it
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in) begin
         unique case (wb_adr_in)
            REG_CTRL: wb_dat_out <= {27'h000_0000, cfg};
            REG_MEASURED: wb_dat_out <= {24'h00_0000, measured};
            REG_SETPOINT: wb_dat_out <= {24'h00_0000, setpoint};
            REG_FEEDBACK: wb_dat_out <= {24'h00_0000, feedback};
            REG_STATUS: wb_dat_out <= {22'h00_0000, tx_wait, synthetic, presence,
                                       ext_disable, override_out, disabled_out, 1'b0, state};
            REG_LAST_OVR: wb_dat_out <= {22'h00_0000, last_ovr_src, last_ovr_val};
            // unmapped and write-only offsets read zero
            default: wb_dat_out <= 32'h0000_0000;
         endcase
      end
   end

   // configuration and measurement registers
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cfg <= CTRL_RESET;
         measured <= MEASURED_RESET;
         setpoint <= SETPOINT_RESET;
         feedback <= FEEDBACK_RESET;
      end else if (wr_lane0) begin
         if (wb_adr_in == REG_CTRL) begin
            cfg.end_mode <= wb_dat_in[CTRL_END_MODE_LSB +: 2];
            cfg.allow_ovr <= wb_dat_in[CTRL_ALLOW_OVR_BIT];
            cfg.reenable_by_disable <= wb_dat_in[CTRL_REENABLE_BIT];
            cfg.coupled_fb1 <= wb_dat_in[CTRL_COUPLED_BIT];
         end
         if (wb_adr_in == REG_MEASURED) begin
            measured <= wb_dat_in[7:0];
         end
         if (wb_adr_in == REG_SETPOINT) begin
            setpoint <= wb_dat_in[7:0];
         end
         // actuator feedback tracks the true output when absolute values are used
         if (wb_adr_in == REG_FEEDBACK) begin
            feedback <= wb_dat_in[7:0];
         end
      end
   end

   // last override telegram, kept for software diagnostics
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         last_ovr_src <= 2'h0;
         last_ovr_val <= 8'h00;
      end else if (ev_ovr) begin
         last_ovr_src <= wb_adr_in[3:2] - 2'h3;
         unique case (wb_adr_in)
            REG_OVR_SWITCH: last_ovr_val <= {7'h00, wb_dat_in[0]};
            REG_OVR_DIM: last_ovr_val <= {4'h0, wb_dat_in[3:0]};
            default: last_ovr_val <= wb_dat_in[7:0];
         endcase
      end
   end

   // control state, everything decided in the decode cycle
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state <= LC_OFF;
         presence <= 1'b0;
         synthetic <= 1'b0;
         ext_disable <= 1'b0;
         timer <= '0;
         tx_wait <= 1'b0;
         cmd_out <= '0;
         disabled_out <= 1'b0;
         override_out <= 1'b0;
      end else begin
         cmd_out.send <= 1'b0;
         if (ev_presence) begin
            presence <= wb_dat_in[0];
            synthetic <= 1'b0;
         end
         if (ev_disable) begin
            ext_disable <= 1'b1;
            state <= LC_DISABLED;
            disabled_out <= 1'b1;
            override_out <= 1'b0;
            tx_wait <= 1'b0;
         end else if (ev_enable && (state == LC_DISABLED ||
                      (state == LC_OVERRIDE && (cfg.reenable_by_disable ||
                       !cfg.coupled_fb1)))) begin
            // regulation started by the end mode in this same cycle wins over the return to LC_OFF
            ext_disable <= 1'b0;
            disabled_out <= 1'b0;
            override_out <= 1'b0;
            tx_wait <= 1'b0;
            timer <= '0;
            presence <= 1'b0;
            synthetic <= 1'b0;
            state <= LC_OFF;
            unique case (cfg.end_mode)
               END_SWITCH_OFF: begin
                  cmd_out <= '{send: 1'b1, on: 1'b0, value: BRIGHT_OFF};
               end
               END_STARTUP: begin
                  presence <= 1'b1;
                  synthetic <= 1'b1;
                  if (below_setpoint) begin
                     state <= LC_STARTUP;
                  end else begin
                     state <= LC_MAIN;
                  end
               end
               // lighting left as it stands
               default: state <= LC_OFF;
            endcase
            // in switch-off mode a presence already standing restarts regulation
            if (cfg.end_mode == END_SWITCH_OFF && presence) begin
               presence <= 1'b1;
               state <= below_setpoint ? LC_STARTUP : LC_MAIN;
            end
         end else if (ev_ovr && state != LC_DISABLED) begin
            state <= LC_OVERRIDE;
            disabled_out <= 1'b1;
            override_out <= 1'b1;
            tx_wait <= 1'b0;
            if (cfg.coupled_fb1) begin
               presence <= 1'b1;
            end
         end else begin
            unique case (state)
               LC_OFF: begin
                  if (ev_presence && wb_dat_in[0]) begin
                     state <= below_setpoint ? LC_STARTUP : LC_MAIN;
                  end
               end
               LC_STARTUP: begin
                  cmd_out <= '{send: 1'b1, on: 1'b1, value: BRIGHT_ON};
                  state <= LC_MAIN;
               end
               LC_MAIN: begin
                  if (ev_presence && !wb_dat_in[0]) begin
                     state <= LC_STEPDOWN;
                     timer <= TIMER_W'(STEPDOWN_CYC - 1);
                  end
               end
               LC_STEPDOWN: begin
                  if (timer == '0) begin
                     cmd_out <= '{send: 1'b1, on: 1'b0, value: BRIGHT_OFF};
                     state <= LC_OFF;
                  end else begin
                     timer <= timer - TIMER_W'(1);
                  end
               end
               LC_OVERRIDE: begin
                  if (!cfg.reenable_by_disable) begin
                     if (cfg.coupled_fb1) begin
                        // presence end still has to wait out the send delay
                        if (ev_presence && !wb_dat_in[0]) begin
                           tx_wait <= 1'b1;
                           timer <= TIMER_W'(TX_DELAY_CYC - 1);
                        end else if (ev_presence && wb_dat_in[0]) begin
                           tx_wait <= 1'b0;
                        end else if (tx_wait && timer == '0) begin
                           tx_wait <= 1'b0;
                           override_out <= 1'b0;
                           disabled_out <= 1'b0;
                           state <= LC_STEPDOWN;
                           timer <= TIMER_W'(STEPDOWN_CYC - 1);
                        end else if (tx_wait) begin
                           timer <= timer - TIMER_W'(1);
                        end
                     end else if (ev_presence && !wb_dat_in[0]) begin
                        override_out <= 1'b0;
                        disabled_out <= 1'b0;
                        state <= LC_STEPDOWN;
                        timer <= TIMER_W'(STEPDOWN_CYC - 1);
                     end
                  end
               end
               LC_DISABLED: begin
                  state <= LC_DISABLED;
               end
            endcase
         end
      end
   end
endmodule : lcou_top

// File: testbench/lcou_top_sva.sv
/* lcou_top_sva: bus, override and end-of-disable checks for lcou_top.
   assumes it is bound to lcou_top and sees only its ports. */
`timescale 1ns/1ns
module lcou_top_sva
   import lcou_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire lcou_cmd_type cmd_out,
   input wire logic disabled_out,
   input wire logic override_out
);
   logic [4:0] ctrl_q;
   logic wr, ovr_wr, en_wr, pr_wr, hold, plain_en;
   assign wr = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];
   assign ovr_wr = wr && wb_adr_in >= REG_OVR_SWITCH && wb_adr_in <= REG_OVR_SCENE;
   assign en_wr = wr && wb_adr_in == REG_DISABLE && !wb_dat_in[0];
   assign pr_wr = wr && wb_adr_in == REG_PRESENCE;
   // coupled override without re-enable by disable ignores enabling, it waits for presence end
   assign hold = override_out && !ctrl_q[CTRL_REENABLE_BIT] && ctrl_q[CTRL_COUPLED_BIT];
   assign plain_en = en_wr && disabled_out && !override_out;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr && wb_adr_in == REG_CTRL) begin
         ctrl_q <= wb_dat_in[4:0];
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   chk_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack missing after request");
   chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   chk_ovr_disables: assert property (override_out |-> disabled_out)
      else $error("override without disable");
   chk_ovr_entry: assert property (
      ovr_wr && ctrl_q[CTRL_ALLOW_OVR_BIT] && !disabled_out |=> override_out)
      else $error("override not entered");
   chk_ovr_barred: assert property (
      ovr_wr && !ctrl_q[CTRL_ALLOW_OVR_BIT] && !override_out |=> !override_out)
      else $error("override entered while barred");
   chk_enable_clears: assert property (en_wr && !hold |=> !disabled_out && !override_out)
      else $error("enable did not clear disable");
   chk_off_sent: assert property (
      plain_en && ctrl_q[1:0] == END_SWITCH_OFF
      |=> ##[0:1] cmd_out.send && !cmd_out.on && cmd_out.value == BRIGHT_OFF)
      else $error("no off command at enable");
   chk_quiet_enable: assert property (
      plain_en && ctrl_q[1:0] == END_NO_TELEGRAM |=> !cmd_out.send [*2])
      else $error("command sent in quiet enable");
   chk_auto_exit: assert property (
      pr_wr && !wb_dat_in[0] && override_out && ctrl_q[4:3] == 2'h0 |=> !override_out)
      else $error("override kept at presence end");
   chk_disable_only: assert property (pr_wr && override_out && ctrl_q[CTRL_REENABLE_BIT]
      |=> override_out)
      else $error("presence ended override");
endmodule : lcou_top_sva

bind lcou_top lcou_top_sva lcou_top_sva_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .cmd_out(cmd_out), .disabled_out(disabled_out),
   .override_out(override_out));

// File: testbench/lcou_actuator.sv
/* lcou_actuator: switching and dimming actuator fed by the command output.
   assumes send is a one-cycle pulse on the system clock. */
`timescale 1ns/1ns
module lcou_actuator
   import lcou_pkg::*;
(
   input wire logic clk_sys_in,
   input wire lcou_cmd_type cmd_in,
   output int on_count_out,
   output int off_count_out,
   output logic [7:0] level_out
);
   initial begin
      on_count_out = 0;
      off_count_out = 0;
      level_out = BRIGHT_OFF;
   end
   // level is the real lighting output, reported back as feedback
   always @(posedge clk_sys_in) begin
      if (cmd_in.send === 1'b1) begin
         level_out <= cmd_in.on ? cmd_in.value : BRIGHT_OFF;
         on_count_out <= on_count_out + int'(cmd_in.on);
         off_count_out <= off_count_out + int'(!cmd_in.on);
      end
   end
endmodule : lcou_actuator

// File: testbench/tb.sv
/* tb: random and corner tests of lcou_top over classic Wishbone.
   assumes 10 MHz clock; checker is bound, actuator model on cmd_out. */
`timescale 1ns/1ns
module tb
   import lcou_pkg::*;
();
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, ack, dis, ovr;
   logic [7:0] adr = 8'h00, lvl, v;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, rd;
   lcou_cmd_type cmd;
   int mismatches = 0, n_tests = 0, n_on, n_off, a, b, t;
   logic [7:0] msk [4] = '{8'h01, 8'h0F, 8'hFF, 8'hFF};
   always #50 clk = ~clk;
   lcou_top lcou_top_i (.clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .cmd_out(cmd), .disabled_out(dis), .override_out(ovr));
   lcou_actuator lcou_actuator_i (.clk_sys_in(clk), .cmd_in(cmd), .on_count_out(n_on),
      .off_count_out(n_off), .level_out(lvl));
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      cyc <= 1'b1;
      we <= w;
      adr <= ad;
      dat <= d;
      sel <= s;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
   initial begin
      rd = $urandom(32'hB28CFAE6);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, REG_CTRL, 0);
      chk("ctrl_reset", 32'(CTRL_RESET), rd);
      bus(0, REG_SETPOINT, 0);
      chk("setpoint_reset", 32'(SETPOINT_RESET), rd);
      bus(1, REG_CTRL, 32'h1F, 4'hE);
      bus(0, 8'h30, 0);
      chk("unmapped", 0, rd);
      bus(0, REG_CTRL, 0);
      chk("lane_refused", 0, rd);
      $display("register test done");
      for (int k = 0; k < 5; k++) begin
         a = n_on;
         b = n_off;
         v = (k == 3) ? 8'h80 + 8'($urandom_range(127)) : 8'($urandom_range(127));
         bus(1, REG_CTRL, 32'(k == 4 ? 1 : (k > 1 ? 2 : k)));
         bus(1, REG_MEASURED, 32'(v));
         bus(1, REG_DISABLE, 1);
         chk("disabled", 1, dis);
         // presence standing at enable in switch-off mode
         if (k == 4) bus(1, REG_PRESENCE, 1);
         bus(1, REG_DISABLE, 0);
         repeat (3) @(posedge clk);
         chk("on_sent", a + int'(k == 2 || k == 4), n_on);
         chk("off_sent", b + int'(k == 1 || k == 4), n_off);
         bus(0, REG_STATUS, 0);
         chk("state", k > 1 ? 2 : 0, rd[2:0]);
         $display("end mode test %0d done", k);
      end
      bus(1, REG_FEEDBACK, 32'(lvl));
      bus(1, REG_OVR_SWITCH, 1);
      chk("barred", 0, ovr);
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         bus(1, REG_CTRL, 32'h0C);
         bus(1, REG_OVR_SWITCH + 8'(4 * k), 32'(v));
         chk("override", 2'b11, {ovr, dis});
         bus(0, REG_LAST_OVR, 0);
         chk("last_ovr", {k[1:0], v & msk[k]}, rd[9:0]);
         bus(1, REG_PRESENCE, 0);
         chk("held", 1, ovr);
         bus(1, REG_DISABLE, 0);
         chk("released", 2'b00, {ovr, dis});
      end
      $display("override test done");
      bus(1, REG_CTRL, 32'h04);
      bus(1, REG_OVR_DIM, 32'($urandom_range(15)));
      bus(1, REG_DISABLE, 0);
      chk("auto_enable", 0, ovr);
      bus(1, REG_OVR_SCENE, 32'($urandom_range(255)));
      bus(1, REG_PRESENCE, 1);
      b = n_off;
      bus(1, REG_PRESENCE, 0);
      chk("auto_exit", 0, ovr);
      t = 0;
      while (n_off == b && t < 1100) begin
         @(posedge clk);
         t++;
      end
      chk("stepdown_off", b + 1, n_off);
      // actuator counts one edge after the off pulse
      chk("stepdown_time", STEPDOWN_CYC + 1, t);
      $display("autonomous test done");
      bus(1, REG_CTRL, 32'h14);
      // readback packs end mode high, then allow, re-enable, coupled
      bus(0, REG_CTRL, 0);
      chk("ctrl_readback", {27'h000_0000, 2'h0, 1'b1, 1'b0, 1'b1}, rd);
      bus(1, REG_OVR_BRIGHT, 32'($urandom));
      bus(0, REG_STATUS, 0);
      chk("forced_presence", 1, rd[7]);
      bus(1, REG_PRESENCE, 0);
      chk("tx_wait", 1, ovr);
      t = 0;
      while (ovr !== 1'b0 && t < 600) begin
         @(posedge clk);
         t++;
      end
      chk("tx_end", 0, ovr);
      chk("tx_delay", TX_DELAY_CYC, t);
      $display("coupled test done");
      end_sim();
   end
endmodule : tb
